//--- logic/four_level_interrupt_controller.sv
// Four-level priority interrupt controller with eleven sources.
// Assumes peripheral requests are levels on i_mclk; the two external
// pins are asynchronous and active low; the core acks a vector and
// signals handler return with one-cycle pulses.
//
// Functional notes
// - Eleven interrupt vectors from eleven sources.
// - Disabled source is never forwarded.
// - Global enable bit 7 masks everything.
// - Level formed from upper and lower bit.
// - Counter array, SPI, keypad vectors fixed.
// - Higher level preempts; same level waits.
// - Level three handler is never preempted.
// - Highest pending level is serviced first.
// - Fixed polling order breaks level ties.
// - Bit 6 gates counter array interrupt.
// - Bit 5 gates timer two interrupt.
// - Bit 4 gates serial port interrupt.
// - Bit 3 gates timer one interrupt.
// - Bit 2 gates external pin one.
// - Bit 1 gates timer zero interrupt.
// - Bit 0 gates external pin zero.
// - Second enable register: USB, SPI, two-wire, keypad.
// - Primary priority bits follow enable bit layout.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps
`include "irq_cfg.svh"

module four_level_interrupt_controller #(
  parameter logic [15:0] VEC_TWO_WIRE = `VEC_TWO_WIRE_DEF,
  parameter logic [15:0] VEC_USB      = `VEC_USB_DEF
) (
  input  wire logic                  i_mclk,
  input  wire logic                  i_rst_n,
  input  wire logic [7:0]            i_addr,
  input  wire logic [7:0]            i_wr_data,
  input  wire logic                  i_wr_en,
  input  wire logic                  i_rd_en,
  output logic      [7:0]            o_rd_data,
  input  wire logic                  i_ext_pin_zero_request_n,
  input  wire logic                  i_ext_pin_one_request_n,
  input  wire logic                  i_timer_zero_req,
  input  wire logic                  i_timer_one_req,
  input  wire logic                  i_timer_two_req,
  input  wire logic                  i_serial_req,
  input  wire logic                  i_counter_array_req,
  input  wire logic                  i_keypad_req,
  input  wire logic                  i_two_wire_req,
  input  wire logic                  i_spi_req,
  input  wire logic                  i_usb_req,
  output logic                       o_irq_valid,
  output irq_pkg::vector_t           o_irq_vector,
  output irq_pkg::level_t            o_irq_level,
  input  wire logic                  i_irq_ack,
  input  wire logic                  i_irq_return,
  output irq_pkg::in_service_t       o_in_service
);
  import irq_pkg::*;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  reg_byte_t   src_en_pri_ff;
  reg_byte_t   src_en_sec_ff;
  reg_byte_t   prio_lo_pri_ff;
  reg_byte_t   prio_hi_pri_ff;
  reg_byte_t   prio_lo_sec_ff;
  reg_byte_t   prio_hi_sec_ff;
  reg_byte_t   rd_data_ff;
  logic [1:0]  ext_zero_sync_ff;
  logic [1:0]  ext_one_sync_ff;
  logic        irq_valid_ff;
  vector_t     irq_vector_ff;
  level_t      irq_level_ff;
  in_service_t in_service_ff;

  logic [`NUM_SRC-1:0] req_raw;
  logic [`NUM_SRC-1:0] src_enable;
  logic [`NUM_SRC-1:0] prio_upper_bit;
  logic [`NUM_SRC-1:0] prio_lower_bit;
  logic [`NUM_SRC-1:0] req_eff;
  logic                found;
  level_t              best_lvl;
  logic [3:0]          best_idx;
  logic                allowed;
  level_t              active_lvl;
  in_service_t         nxt_in_service;
  reg_byte_t           nxt_rd_data;
  logic                global_irq_enable;

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function automatic vector_t vec_of(input logic [3:0] idx);
    vector_t v;
    v = `VEC_EXT_ZERO;
    case (idx)
      4'(`SRC_EXT_ZERO):      v = `VEC_EXT_ZERO;
      4'(`SRC_TIMER_ZERO):    v = `VEC_TIMER_ZERO;
      4'(`SRC_EXT_ONE):       v = `VEC_EXT_ONE;
      4'(`SRC_TIMER_ONE):     v = `VEC_TIMER_ONE;
      4'(`SRC_SERIAL):        v = `VEC_SERIAL;
      4'(`SRC_TIMER_TWO):     v = `VEC_TIMER_TWO;
      4'(`SRC_COUNTER_ARRAY): v = `VEC_COUNTER_ARRAY;
      4'(`SRC_KEYPAD):        v = `VEC_KEYPAD;
      4'(`SRC_TWO_WIRE):      v = VEC_TWO_WIRE;
      4'(`SRC_SPI):           v = `VEC_SPI;
      4'(`SRC_USB):           v = VEC_USB;
      default:                v = `VEC_EXT_ZERO;
    endcase
    return v;
  endfunction

  function automatic level_t highest_in_service(input in_service_t s);
    level_t l;
    l = 2'h0;
    for (int k = 0; k < 4; k++) begin
      if (s[k]) begin
        l = 2'(k);
      end
    end
    return l;
  endfunction

  function automatic level_t level_of(input logic upper, input logic lower);
    return {upper, lower};
  endfunction

  // Places primary bits 6..0 and the four secondary bits at their source index
  function automatic logic [`NUM_SRC-1:0] gather(input reg_byte_t pri, input reg_byte_t sec);
    logic [`NUM_SRC-1:0] g;
    g                     = '0;
    g[`SRC_EXT_ZERO]      = pri[`BIT_PRI_EXT_ZERO];
    g[`SRC_TIMER_ZERO]    = pri[`BIT_PRI_TIMER_ZERO];
    g[`SRC_EXT_ONE]       = pri[`BIT_PRI_EXT_ONE];
    g[`SRC_TIMER_ONE]     = pri[`BIT_PRI_TIMER_ONE];
    g[`SRC_SERIAL]        = pri[`BIT_PRI_SERIAL];
    g[`SRC_TIMER_TWO]     = pri[`BIT_PRI_TIMER_TWO];
    g[`SRC_COUNTER_ARRAY] = pri[`BIT_PRI_COUNTER_ARRAY];
    g[`SRC_KEYPAD]        = sec[`BIT_SEC_KEYPAD];
    g[`SRC_TWO_WIRE]      = sec[`BIT_SEC_TWO_WIRE];
    g[`SRC_SPI]           = sec[`BIT_SEC_SPI];
    g[`SRC_USB]           = sec[`BIT_SEC_USB];
    return g;
  endfunction

  // ---------------------------------------------------------------
  // External pin synchronisers
  // ---------------------------------------------------------------
  // Only the second stage feeds logic; the first may still be settling
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ext_zero_sync_ff <= `RST_SYNC;
    end else begin
      ext_zero_sync_ff <= {ext_zero_sync_ff[0], i_ext_pin_zero_request_n};
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ext_one_sync_ff <= `RST_SYNC;
    end else begin
      ext_one_sync_ff <= {ext_one_sync_ff[0], i_ext_pin_one_request_n};
    end
  end

  // ---------------------------------------------------------------
  // Source mapping
  // ---------------------------------------------------------------
  always_comb begin
    req_raw                     = '0;
    req_raw[`SRC_EXT_ZERO]      = ~ext_zero_sync_ff[1];
    req_raw[`SRC_TIMER_ZERO]    = i_timer_zero_req;
    req_raw[`SRC_EXT_ONE]       = ~ext_one_sync_ff[1];
    req_raw[`SRC_TIMER_ONE]     = i_timer_one_req;
    req_raw[`SRC_SERIAL]        = i_serial_req;
    req_raw[`SRC_TIMER_TWO]     = i_timer_two_req;
    req_raw[`SRC_COUNTER_ARRAY] = i_counter_array_req;
    req_raw[`SRC_KEYPAD]        = i_keypad_req;
    req_raw[`SRC_TWO_WIRE]      = i_two_wire_req;
    req_raw[`SRC_SPI]           = i_spi_req;
    req_raw[`SRC_USB]           = i_usb_req;
  end

  // One enable bit per source
  always_comb begin
    src_enable = '0;
    src_enable[`SRC_EXT_ZERO]      = src_en_pri_ff[`BIT_PRI_EXT_ZERO];
    src_enable[`SRC_TIMER_ZERO]    = src_en_pri_ff[`BIT_PRI_TIMER_ZERO];
    src_enable[`SRC_EXT_ONE]       = src_en_pri_ff[`BIT_PRI_EXT_ONE];
    src_enable[`SRC_TIMER_ONE]     = src_en_pri_ff[`BIT_PRI_TIMER_ONE];
    src_enable[`SRC_SERIAL]        = src_en_pri_ff[`BIT_PRI_SERIAL];
    src_enable[`SRC_TIMER_TWO]     = src_en_pri_ff[`BIT_PRI_TIMER_TWO];
    src_enable[`SRC_COUNTER_ARRAY] = src_en_pri_ff[`BIT_PRI_COUNTER_ARRAY];
    src_enable[`SRC_KEYPAD]        = src_en_sec_ff[`BIT_SEC_KEYPAD];
    src_enable[`SRC_TWO_WIRE]      = src_en_sec_ff[`BIT_SEC_TWO_WIRE];
    src_enable[`SRC_SPI]           = src_en_sec_ff[`BIT_SEC_SPI];
    src_enable[`SRC_USB]           = src_en_sec_ff[`BIT_SEC_USB];
  end

  // ---------------------------------------------------------------
  // Priority levels
  // ---------------------------------------------------------------
  assign prio_upper_bit = gather(prio_hi_pri_ff, prio_hi_sec_ff);
  assign prio_lower_bit = gather(prio_lo_pri_ff, prio_lo_sec_ff);

  assign global_irq_enable = src_en_pri_ff[`BIT_GLOBAL_EN];
  assign req_eff = global_irq_enable ? (req_raw & src_enable) : '0;

  // ---------------------------------------------------------------
  // Arbitration
  // ---------------------------------------------------------------
  // Strict compare keeps the earliest source among equal levels
  always_comb begin
    found    = 1'b0;
    best_lvl = 2'h0;
    best_idx = 4'h0;
    for (int i = 0; i < `NUM_SRC; i++) begin
      if (req_eff[i] &&
          (!found || level_of(prio_upper_bit[i], prio_lower_bit[i]) > best_lvl)) begin
        found    = 1'b1;
        best_lvl = level_of(prio_upper_bit[i], prio_lower_bit[i]);
        best_idx = 4'(i);
      end
    end
  end

  assign active_lvl = highest_in_service(in_service_ff);
  // Level three can never be exceeded, so it blocks everything
  assign allowed = found && ((in_service_ff == 4'h0) || (best_lvl > active_lvl));

  // ---------------------------------------------------------------
  // Vector offer to the core
  // ---------------------------------------------------------------
  // Offer drops for one cycle after an ack so the new in-service
  // level is seen before the next offer is judged.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      irq_valid_ff <= 1'b0;
    end else begin
      irq_valid_ff <= allowed && !i_irq_ack && !i_irq_return;
    end
  end

  // Vector and level follow the winner every cycle; only valid qualifies them
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      irq_vector_ff <= `RST_VECTOR;
      irq_level_ff  <= `RST_LEVEL;
    end else begin
      irq_vector_ff <= vec_of(best_idx);
      irq_level_ff  <= best_lvl;
    end
  end

  // ---------------------------------------------------------------
  // In-service levels
  // ---------------------------------------------------------------
  // Return retires the running handler before a new one is entered
  always_comb begin
    nxt_in_service = in_service_ff;
    if (i_irq_return && (in_service_ff != 4'h0)) begin
      nxt_in_service[active_lvl] = 1'b0;
    end
    if (i_irq_ack && irq_valid_ff) begin
      nxt_in_service[irq_level_ff] = 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      in_service_ff <= 4'h0;
    end else begin
      in_service_ff <= nxt_in_service;
    end
  end

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  // Reserved bits are masked on entry, so they can never raise a request
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      src_en_pri_ff <= `RST_REG;
      src_en_sec_ff <= `RST_REG;
    end else if (i_wr_en) begin
      case (i_addr)
        `OFS_SRC_EN_PRI: src_en_pri_ff <= i_wr_data & `MASK_EN_PRI;
        `OFS_SRC_EN_SEC: src_en_sec_ff <= i_wr_data & `MASK_SEC;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      prio_lo_pri_ff <= `RST_REG;
      prio_hi_pri_ff <= `RST_REG;
      prio_lo_sec_ff <= `RST_REG;
      prio_hi_sec_ff <= `RST_REG;
    end else if (i_wr_en) begin
      case (i_addr)
        `OFS_PRIO_LO_PRI: prio_lo_pri_ff <= i_wr_data & `MASK_PRI;
        `OFS_PRIO_HI_PRI: prio_hi_pri_ff <= i_wr_data & `MASK_PRI;
        `OFS_PRIO_LO_SEC: prio_lo_sec_ff <= i_wr_data & `MASK_SEC;
        `OFS_PRIO_HI_SEC: prio_hi_sec_ff <= i_wr_data & `MASK_SEC;
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Register reads
  // ---------------------------------------------------------------
  // Reserved bits are stored as zero, so they read back as zero
  always_comb begin
    nxt_rd_data = 8'h00;
    case (i_addr)
      `OFS_SRC_EN_PRI:  nxt_rd_data = src_en_pri_ff;
      `OFS_SRC_EN_SEC:  nxt_rd_data = src_en_sec_ff;
      `OFS_PRIO_LO_PRI: nxt_rd_data = prio_lo_pri_ff;
      `OFS_PRIO_HI_PRI: nxt_rd_data = prio_hi_pri_ff;
      `OFS_PRIO_LO_SEC: nxt_rd_data = prio_lo_sec_ff;
      `OFS_PRIO_HI_SEC: nxt_rd_data = prio_hi_sec_ff;
      default:          nxt_rd_data = 8'h00;
    endcase
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      rd_data_ff <= 8'h00;
    end else if (i_rd_en) begin
      rd_data_ff <= nxt_rd_data;
    end else begin
      rd_data_ff <= 8'h00;
    end
  end

  assign o_rd_data    = rd_data_ff;
  assign o_irq_valid  = irq_valid_ff;
  assign o_irq_vector = irq_vector_ff;
  assign o_irq_level  = irq_level_ff;
  assign o_in_service = in_service_ff;

endmodule

//--- logic/irq_cfg.svh
// Register offsets, field positions, vectors and widths of the
// interrupt controller. Assumes a byte-wide register port.
`ifndef IRQ_CFG_SVH
`define IRQ_CFG_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define OFS_SRC_EN_PRI    8'hA8
`define OFS_SRC_EN_SEC    8'hB1
`define OFS_PRIO_LO_PRI   8'hB8
`define OFS_PRIO_HI_PRI   8'hB7
`define OFS_PRIO_LO_SEC   8'hB2
`define OFS_PRIO_HI_SEC   8'hB3

// ---------------------------------------------------------------
// Field positions and masks
// ---------------------------------------------------------------
`define BIT_GLOBAL_EN     7
`define MASK_PRI          8'h7F
`define MASK_SEC          8'h47
`define MASK_EN_PRI       8'hFF
`define BIT_SEC_KEYPAD    0
`define BIT_SEC_TWO_WIRE  1
`define BIT_SEC_SPI       2
`define BIT_SEC_USB       6
`define BIT_PRI_EXT_ZERO      0
`define BIT_PRI_TIMER_ZERO    1
`define BIT_PRI_EXT_ONE       2
`define BIT_PRI_TIMER_ONE     3
`define BIT_PRI_SERIAL        4
`define BIT_PRI_TIMER_TWO     5
`define BIT_PRI_COUNTER_ARRAY 6
`define RST_REG           8'h00
`define RST_SYNC          2'h3
`define RST_VECTOR        16'h0000
`define RST_LEVEL         2'h0

// ---------------------------------------------------------------
// Sources, in polling order
// ---------------------------------------------------------------
`define NUM_SRC           11
`define SRC_EXT_ZERO      0
`define SRC_TIMER_ZERO    1
`define SRC_EXT_ONE       2
`define SRC_TIMER_ONE     3
`define SRC_SERIAL        4
`define SRC_TIMER_TWO     5
`define SRC_COUNTER_ARRAY 6
`define SRC_KEYPAD        7
`define SRC_TWO_WIRE      8
`define SRC_SPI           9
`define SRC_USB           10

// ---------------------------------------------------------------
// Vector addresses
// ---------------------------------------------------------------
`define VEC_EXT_ZERO      16'h0003
`define VEC_TIMER_ZERO    16'h000B
`define VEC_EXT_ONE       16'h0013
`define VEC_TIMER_ONE     16'h001B
`define VEC_SERIAL        16'h0023
`define VEC_TIMER_TWO     16'h002B
`define VEC_COUNTER_ARRAY 16'h0033
`define VEC_KEYPAD        16'h003B
`define VEC_SPI           16'h004B
`define VEC_TWO_WIRE_DEF  16'h0043
`define VEC_USB_DEF       16'h0053

`endif

//--- logic/irq_pkg.sv
// Types shared by the interrupt controller and its bench.
// Assumes irq_cfg.svh is on the include path.
package irq_pkg;
  typedef logic [1:0]  level_t;
  typedef logic [15:0] vector_t;
  typedef logic [7:0]  reg_byte_t;
  typedef logic [3:0]  in_service_t;
endpackage

//--- tb/irq_core_model.sv
// Behavioural core that takes an offered vector after a set wait.
// Assumes the controller holds its offer until it samples the ack.
`timescale 1ns/10ps
module irq_core_model
  import irq_pkg::*;
(
  input  wire logic              i_mclk,
  input  wire logic              i_rst_n,
  input  wire logic              i_valid,
  input  wire irq_pkg::vector_t  i_vector,
  input  wire irq_pkg::level_t   i_level,
  input  wire logic              i_take_on,
  input  wire logic [3:0]        i_wait,
  output logic                   o_ack,
  output irq_pkg::vector_t       o_vector,
  output irq_pkg::level_t        o_level,
  output int                     o_takes
);
  logic [3:0] wait_ff;
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_ack <= 1'b0;
      wait_ff <= 4'h0;
      o_vector <= 16'h0000;
      o_level <= 2'h0;
      o_takes <= 0;
    end else if (i_take_on && i_valid && !o_ack && wait_ff == i_wait) begin
      o_ack <= 1'b1;
      o_vector <= i_vector;
      o_level <= i_level;
      o_takes <= o_takes + 1;
      wait_ff <= 4'h0;
    end else begin
      o_ack <= 1'b0;
      wait_ff <= (i_take_on && i_valid && !o_ack) ? wait_ff + 4'h1 : 4'h0;
    end
  end
endmodule

//--- tb/irq_ctrl_properties.sv
// Port-level checks of the interrupt controller.
// Assumes it is bound onto the controller with default vector parameters.
`timescale 1ns/10ps
`include "irq_cfg.svh"
module irq_ctrl_checker
  import irq_pkg::*;
(
  input wire logic                 i_mclk,
  input wire logic                 i_rst_n,
  input wire logic [7:0]           i_addr,
  input wire logic [7:0]           i_wr_data,
  input wire logic                 i_wr_en,
  input wire logic                 i_rd_en,
  input wire logic [7:0]           o_rd_data,
  input wire logic                 o_irq_valid,
  input wire irq_pkg::vector_t     o_irq_vector,
  input wire irq_pkg::level_t      o_irq_level,
  input wire logic                 i_irq_ack,
  input wire irq_pkg::in_service_t o_in_service
);
  reg_byte_t  en_ff;
  reg_byte_t  lo_ff;
  reg_byte_t  hi_ff;
  logic [2:0] idx;

  // --------------------------------
  // Shadows of the primary registers
  // --------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      en_ff <= 8'h00;
      lo_ff <= 8'h00;
      hi_ff <= 8'h00;
    end else if (i_wr_en) begin
      if (i_addr == `OFS_SRC_EN_PRI) en_ff <= i_wr_data;
      if (i_addr == `OFS_PRIO_LO_PRI) lo_ff <= i_wr_data;
      if (i_addr == `OFS_PRIO_HI_PRI) hi_ff <= i_wr_data;
    end
  end
  // Primary vectors sit eight apart, so bits 5..3 give the source bit
  assign idx = o_irq_vector[5:3];

  // --------------------------------
  // Properties
  // --------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  sequence s_take;
    o_irq_valid && i_irq_ack;
  endsequence
  sequence s_prim;
    o_irq_valid && o_irq_vector <= 16'h0033;
  endsequence

  a_global_gate: assert property (
    $rose(o_irq_valid) |-> $past(en_ff[7])) else $error("offer with global enable off");
  a_src_gate: assert property (
    s_prim |-> ((8'h01 << idx) & $past(en_ff)) != 8'h00) else $error("offer from masked source");
  a_level_pair: assert property (
    s_prim |-> o_irq_level == {|((8'h01 << idx) & $past(hi_ff)), |((8'h01 << idx) & $past(lo_ff))})
    else $error("offer level wrong");
  a_vector_set: assert property (
    o_irq_valid |-> o_irq_vector inside {16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023,
      16'h002B, 16'h0033, 16'h003B, `VEC_TWO_WIRE_DEF, 16'h004B, `VEC_USB_DEF})
    else $error("illegal vector");
  a_take_service: assert property (
    s_take |=> !o_irq_valid && o_in_service[$past(o_irq_level)]) else $error("ack not served");
  a_above_service: assert property (
    o_irq_valid |-> (o_in_service >> o_irq_level) == 4'h0) else $error("offer not above service");
  a_top_hold: assert property (
    o_in_service[3] |-> !o_irq_valid) else $error("top level preempted");
  a_rd_idle: assert property (
    !$past(i_rd_en) |-> o_rd_data == 8'h00) else $error("read data outside slot");
endmodule

bind four_level_interrupt_controller irq_ctrl_checker u_chk (.i_mclk, .i_rst_n, .i_addr,
  .i_wr_data, .i_wr_en, .i_rd_en, .o_rd_data, .o_irq_valid, .o_irq_vector, .o_irq_level,
  .i_irq_ack, .o_in_service);

//--- tb/tb_top.sv
// Self-checking bench of the interrupt controller.
// Assumes the core model and the bound checker are compiled alongside.
`timescale 1ns/10ps
module tb_top;
  import irq_pkg::*;
  logic        i_mclk = 1'b0;
  logic        i_rst_n = 1'b0;
  reg_byte_t   addr = 8'h00;
  reg_byte_t   wdata = 8'h00;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic [10:0] src = 11'h000;
  logic        ack_on = 1'b1;
  logic [3:0]  lat = 4'h0;
  logic        irq_ret = 1'b0;
  reg_byte_t   rd_data;
  logic        valid;
  logic        ack;
  vector_t     vec;
  vector_t     got_vec;
  level_t      lvl;
  level_t      got_lvl;
  in_service_t insvc;
  int          takes;
  int          err_total = 0;
  int          check_count = 0;
  vector_t     vecs[11] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023, 16'h002B,
                            16'h0033, 16'h003B, 16'h0043, 16'h004B, 16'h0053};
  int          bits[11] = '{0, 1, 2, 3, 4, 5, 6, 0, 1, 2, 6};
  reg_byte_t   offs[6] = '{8'hA8, 8'hB1, 8'hB8, 8'hB7, 8'hB2, 8'hB3};
  reg_byte_t   masks[6] = '{8'hFF, 8'h47, 8'h7F, 8'h7F, 8'h47, 8'h47};

  always #4 i_mclk = ~i_mclk;

  four_level_interrupt_controller u_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(addr),
    .i_wr_data(wdata), .i_wr_en(wr_en), .i_rd_en(rd_en), .o_rd_data(rd_data),
    .i_ext_pin_zero_request_n(~src[0]), .i_ext_pin_one_request_n(~src[2]),
    .i_timer_zero_req(src[1]), .i_timer_one_req(src[3]), .i_serial_req(src[4]),
    .i_timer_two_req(src[5]), .i_counter_array_req(src[6]), .i_keypad_req(src[7]),
    .i_two_wire_req(src[8]), .i_spi_req(src[9]), .i_usb_req(src[10]),
    .o_irq_valid(valid), .o_irq_vector(vec), .o_irq_level(lvl), .i_irq_ack(ack),
    .i_irq_return(irq_ret), .o_in_service(insvc));
  irq_core_model u_core (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_valid(valid),
    .i_vector(vec), .i_level(lvl), .i_take_on(ack_on), .i_wait(lat), .o_ack(ack),
    .o_vector(got_vec), .o_level(got_lvl), .o_takes(takes));

  // --------------------------------
  // Access and check tasks
  // --------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_mclk);
  endtask
  task automatic wr(input reg_byte_t a, input reg_byte_t d);
    @(posedge i_mclk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge i_mclk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input reg_byte_t a, input reg_byte_t exp);
    @(posedge i_mclk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge i_mclk);
    rd_en <= 1'b0;
    #1;
    chk(rd_data, exp);
  endtask
  task automatic ret();
    @(posedge i_mclk);
    irq_ret <= 1'b1;
    @(posedge i_mclk);
    irq_ret <= 1'b0;
  endtask
  // Waits for the core to take one vector, then compares what it got
  task automatic take(input vector_t v, input level_t l);
    int t0;
    t0 = takes;
    repeat (20) if (takes == t0) @(posedge i_mclk);
    chk(takes, t0 + 1);
    chk(got_vec, v);
    chk(got_lvl, l);
  endtask
  task automatic results();
    $display("checks=%0d mismatches=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // --------------------------------
  // Tests
  // --------------------------------
  initial begin
    idle(12);
    i_rst_n <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      rd(offs[k], 8'h00);
      wr(offs[k], 8'hFF);
      rd(offs[k], masks[k]);
      wr(offs[k], 8'h00);
    end
    wr(8'hA9, 8'hFF);
    rd(8'hA9, 8'h00);
    $display("register test done");
    for (int i = 0; i < 11; i++) begin
      lat <= 4'(i % 3);
      src[i] <= 1'b1;
      idle(6);
      chk(valid, 1'b0);
      wr(8'hB1, 8'h47);
      wr(8'hA8, 8'h7F);
      idle(6);
      chk(valid, 1'b0);
      wr(8'hB1, i > 6 ? 8'h01 << bits[i] : 8'h00);
      wr(8'hA8, i < 7 ? 8'h80 | (8'h01 << bits[i]) : 8'h80);
      take(vecs[i], 2'h0);
      @(posedge i_mclk);
      src[i] <= 1'b0;
      idle(3);
      ret();
      wr(8'hA8, 8'h00);
      wr(8'hB1, 8'h00);
    end
    $display("vector test done");
    ack_on <= 1'b0;
    wr(8'hB8, 8'h02);
    wr(8'hB7, 8'h08);
    wr(8'hA8, 8'h8B);
    src <= 11'h00B;
    idle(6);
    chk(vec, 16'h001B);
    chk(lvl, 2'h2);
    ack_on <= 1'b1;
    take(16'h001B, 2'h2);
    src[3] <= 1'b0;
    idle(6);
    chk(insvc, 4'h4);
    chk(valid, 1'b0);
    src[4] <= 1'b1;
    wr(8'hA8, 8'h9B);
    wr(8'hB7, 8'h18);
    wr(8'hB8, 8'h12);
    take(16'h0023, 2'h3);
    wr(8'hB7, 8'h1A);
    idle(4);
    chk(insvc, 4'hC);
    chk(valid, 1'b0);
    src[4] <= 1'b0;
    ret();
    take(16'h000B, 2'h3);
    src[1] <= 1'b0;
    idle(3);
    ret();
    ret();
    take(16'h0003, 2'h0);
    src[0] <= 1'b0;
    idle(3);
    ret();
    $display("priority test done");
    wr(8'hB7, 8'h00);
    wr(8'hB8, 8'h00);
    wr(8'hA8, 8'h98);
    ack_on <= 1'b0;
    src <= 11'h018;
    idle(6);
    chk(vec, 16'h001B);
    ack_on <= 1'b1;
    take(16'h001B, 2'h0);
    src[3] <= 1'b0;
    idle(3);
    ret();
    take(16'h0023, 2'h0);
    src <= 11'h000;
    idle(3);
    ret();
    $display("polling test done");
    wr(8'hB2, 8'h04);
    wr(8'hB3, 8'h40);
    wr(8'hB1, 8'h45);
    wr(8'hA8, 8'h80);
    ack_on <= 1'b0;
    src <= 11'h680;
    idle(6);
    chk(vec, 16'h0053);
    chk(lvl, 2'h2);
    ack_on <= 1'b1;
    take(16'h0053, 2'h2);
    src[10] <= 1'b0;
    ret();
    take(16'h004B, 2'h1);
    $display("secondary test done");
    i_rst_n <= 1'b0;
    idle(2);
    chk(insvc, 4'h0);
    chk(valid, 1'b0);
    i_rst_n <= 1'b1;
    rd(8'hB1, 8'h00);
    rd(8'hB3, 8'h00);
    idle(6);
    chk(valid, 1'b0);
    src <= 11'h000;
    $display("reset test done");
    results();
  end

  initial begin
    idle(20000);
    err_total++;
    results();
  end
endmodule
